// >>> cmbp_ic_model.sv
`timescale 1ns/1ns
`default_nettype none
// Interconnect side: readies come late at random, and one response
// answers each request, an error one while icErr is high.
module cmbp_ic_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic masterBusClockEnable,
  input wire logic icErr,
  input wire logic awValid,
  output logic awReady,
  input wire logic wValid,
  output logic wReady,
  output logic bValid,
  input wire logic bReady,
  output logic [4:0] bId,
  output logic [1:0] bResp,
  input wire logic arValid,
  output logic arReady,
  output logic rValid,
  input wire logic rReady,
  output logic [127:0] rData,
  output logic [5:0] rId,
  output logic [3:0] rResp,
  output logic rLast
);
  logic gotA, gotW, gotR;
  assign bId = 5'h00;
  assign rId = 6'h00;
  ////////////////////////////////////////////////////////////////////////////
  // On release, bResp and rData show the inverse of the last value, so stale data never matches.
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      {awReady, wReady, arReady, bValid, rValid, rLast, gotA, gotW, gotR} <= '0;
      bResp <= 2'h0;
      rResp <= 4'h0;
      rData <= '0;
    end
    else if (masterBusClockEnable)
    begin
      awReady <= awValid && !awReady && !gotA && $urandom % 2;
      wReady <= wValid && !wReady && !gotW && $urandom % 2;
      arReady <= arValid && !arReady && !gotR && $urandom % 2;
      gotA <= gotA ? !(bValid && bReady) : (awValid && awReady);
      gotW <= gotW ? !(bValid && bReady) : (wValid && wReady);
      gotR <= gotR ? !(rValid && rReady) : (arValid && arReady);
      if (bValid && bReady)
      begin
        bValid <= 1'b0;
        bResp <= ~bResp;
      end
      else if (gotA && gotW && !bValid)
      begin
        bValid <= 1'b1;
        bResp <= icErr ? 2'h2 : 2'h0;
      end
      if (rValid && rReady)
      begin
        {rValid, rLast} <= 2'b00;
        rData <= ~rData;
      end
      else if (gotR && !rValid && $urandom % 2)
      begin
        {rValid, rLast} <= 2'b11;
        rResp <= icErr ? 4'h2 : 4'h0;
      end
    end
endmodule
`default_nettype wire

// >>> cmbp_pkg.sv
`default_nettype none
package cmbp_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR_LO = 8'h04;
  localparam logic [7:0] OFS_ADDR_HI = 8'h08;
  localparam logic [7:0] OFS_WDATA = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int CTRL_GO_WR = 0;
  localparam int CTRL_GO_RD = 1;
  localparam int CTRL_CLR_ERR = 2;
  localparam int CTRL_CLS_LSB = 4;
  localparam int CTRL_BAR = 6;
  localparam int CTRL_CACHE_LSB = 8;
  localparam int CTRL_PROT_LSB = 12;
  localparam logic [1:0] CLS_INNER = 2'h1;
  localparam logic [1:0] CLS_OUTER = 2'h2;
  localparam logic [1:0] CLS_MAINT = 2'h3;
  localparam logic [1:0] DOM_NONSH = 2'h0;
  localparam logic [1:0] DOM_INNER = 2'h1;
  localparam logic [1:0] DOM_OUTER = 2'h2;
  localparam logic [1:0] BAR_NONE = 2'h0;
  localparam logic [1:0] BAR_MEM = 2'h1;
  localparam logic [3:0] AR_SNOOP_PLAIN = 4'h0;
  localparam logic [3:0] AR_SNOOP_MAINT = 4'h9;
  localparam logic [2:0] AW_SNOOP_PLAIN = 3'h0;
  localparam logic [4:0] CR_MISS = 5'h00;
  localparam logic [4:0] CR_HIT_DIRTY = 5'h05;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] BURST_LEN = 8'h00;
  localparam logic [2:0] BURST_SIZE = 3'h4;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [4:0] WR_ID = 5'h00;
  localparam logic [5:0] RD_ID = 6'h00;
  localparam int LINE_LSB = 4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WADDR = 3'b001,
    ST_WRESP = 3'b010,
    ST_RADDR = 3'b011,
    ST_RDATA = 3'b100
  } cmbp_state_t;
  typedef enum logic {
    SN_IDLE = 1'b0,
    SN_BUSY = 1'b1
  } cmbp_snoop_state_t;
endpackage
`default_nettype wire

// >>> cmbp_port.sv
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Broadcast straps captured once after reset.
// - Inner shareable goes out only if enabled.
// - Outer shareable goes out only if enabled.
// - Maintenance forwarded only if enabled.
// - Barriers suppressed when barrier suppress set.
// - Bus moves only on enabled clock edges.
// - Unattributable bus error drives irq low.
// - Write address channel fields and widths.
// - Write data channel 128 bits, strobes.
// - Read address channel fields and widths.
// - Each snoop gets a 5-bit response.
// - Dirty hit returns one snoop data beat.
// - Acknowledge pulses after bus read and write; none for a local one.
// - Standby idle needs all WFI, inactive, idle.
module cmbp_port #(
  parameter int NCPU = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic masterBusClockEnable,
  input wire logic snoopSideInactive,
  input wire logic innerShareBroadcastEn,
  input wire logic outerShareBroadcastEn,
  input wire logic maintenanceBroadcastEn,
  input wire logic barrierSuppress,
  input wire logic [NCPU-1:0] cpuWfiStandby,
  output logic busErrorIrqN,
  output logic sharedCacheIdleStandby,
  output logic awValid,
  input wire logic awReady,
  output logic [39:0] awAddr,
  output logic [4:0] awId,
  output logic [7:0] awLen,
  output logic [2:0] awSize,
  output logic [1:0] awBurst,
  output logic [3:0] awCache,
  output logic [2:0] awProt,
  output logic [1:0] awDomain,
  output logic [1:0] awBar,
  output logic [2:0] awSnoop,
  output logic awLock,
  output logic wValid,
  input wire logic wReady,
  output logic [127:0] wData,
  output logic [15:0] wStrb,
  output logic [4:0] wId,
  output logic wLast,
  input wire logic bValid,
  output logic bReady,
  input wire logic [4:0] bId,
  input wire logic [1:0] bResp,
  output logic arValid,
  input wire logic arReady,
  output logic [39:0] arAddr,
  output logic [5:0] arId,
  output logic [7:0] arLen,
  output logic [2:0] arSize,
  output logic [1:0] arBurst,
  output logic [3:0] arCache,
  output logic [2:0] arProt,
  output logic [1:0] arDomain,
  output logic [1:0] arBar,
  output logic [3:0] arSnoop,
  output logic arLock,
  input wire logic rValid,
  output logic rReady,
  input wire logic [127:0] rData,
  input wire logic [5:0] rId,
  input wire logic [3:0] rResp,
  input wire logic rLast,
  input wire logic acValid,
  output logic acReady,
  input wire logic [39:0] acAddr,
  input wire logic [2:0] acProt,
  input wire logic [3:0] acSnoop,
  output logic crValid,
  input wire logic crReady,
  output logic [4:0] crResp,
  output logic cdValid,
  input wire logic cdReady,
  output logic [127:0] cdData,
  output logic cdLast,
  output logic readAck,
  output logic writeAck
);
  typedef struct packed {
    cmbp_pkg::cmbp_state_t st;
    logic cfgValid;
    logic [3:0] cfg;
    logic pendWr;
    logic pendRd;
    logic [1:0] cls;
    logic bar;
    logic [3:0] cache;
    logic [2:0] prot;
    logic [39:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic err;
    logic irqN;
    logic lastLocal;
    logic [1:0] lastResp;
    logic [39:0] lineAddr;
    logic [127:0] lineData;
    logic lineDirty;
    logic [39:0] busAddr;
    logic [31:0] busW;
    logic [3:0] busCache;
    logic [2:0] busProt;
    logic [1:0] dom;
    logic [1:0] barOut;
    logic [3:0] arSn;
    logic awV;
    logic wV;
    logic bRdy;
    logic arV;
    logic rRdy;
    logic rack;
    logic wack;
    logic idleStby;
    logic awHeld;
    logic [7:0] awA;
    logic wHeld;
    logic [31:0] wD;
    logic [3:0] wS;
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic sbV;
    logic [1:0] sbR;
    logic srV;
    logic [31:0] srD;
    logic [1:0] srR;
  } cmbp_port_t;
  cmbp_port_t s;
  cmbp_port_t n;
  logic busy;
  logic clrErr;
  logic dirtyClr;
  logic snoopIdle;

  // Bits cfg[0..3]: inner, outer, maintenance, barrier suppress.
  function automatic logic staysLocal(input logic [1:0] cls, input logic bar, input logic [3:0] cfg);
    staysLocal = (cls == cmbp_pkg::CLS_INNER && !cfg[0]) || (cls == cmbp_pkg::CLS_OUTER && !cfg[1])
      || (cls == cmbp_pkg::CLS_MAINT && !cfg[2]) || (bar && cfg[3]);
  endfunction

  function automatic logic [1:0] clsDomain(input logic [1:0] cls);
    case (cls)
      cmbp_pkg::CLS_INNER: clsDomain = cmbp_pkg::DOM_INNER;
      cmbp_pkg::CLS_OUTER: clsDomain = cmbp_pkg::DOM_OUTER;
      cmbp_pkg::CLS_MAINT: clsDomain = cmbp_pkg::DOM_INNER;
      default: clsDomain = cmbp_pkg::DOM_NONSH;
    endcase
  endfunction

  function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      mrg[8*i+:8] = be[i] ? nw[8*i+:8] : old[8*i+:8];
  endfunction

  assign busy = s.pendWr || s.pendRd || s.st != cmbp_pkg::ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = s;
    clrErr = 1'b0;
    n.rack = 1'b0;
    n.wack = 1'b0;
    if (s_axi_awvalid && s.awRdy)
    begin
      n.awHeld = 1'b1;
      n.awA = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wRdy)
    begin
      n.wHeld = 1'b1;
      n.wD = s_axi_wdata;
      n.wS = s_axi_wstrb;
    end
    if (s.sbV && s_axi_bready) n.sbV = 1'b0;
    if (s.awHeld && s.wHeld && !s.sbV)
    begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.sbV = 1'b1;
      n.sbR = cmbp_pkg::RESP_OKAY;
      case (s.awA)
        cmbp_pkg::OFS_CTRL:
        begin
          if (s.wS[0])
          begin
            // A start request while an operation is in flight is dropped.
            if (s.wD[cmbp_pkg::CTRL_GO_WR] && !busy) n.pendWr = 1'b1;
            if (s.wD[cmbp_pkg::CTRL_GO_RD] && !s.wD[cmbp_pkg::CTRL_GO_WR] && !busy) n.pendRd = 1'b1;
            clrErr = s.wD[cmbp_pkg::CTRL_CLR_ERR];
            n.cls = s.wD[cmbp_pkg::CTRL_CLS_LSB+:2];
            n.bar = s.wD[cmbp_pkg::CTRL_BAR];
          end
          if (s.wS[1])
          begin
            n.cache = s.wD[cmbp_pkg::CTRL_CACHE_LSB+:4];
            n.prot = s.wD[cmbp_pkg::CTRL_PROT_LSB+:3];
          end
        end
        cmbp_pkg::OFS_ADDR_LO: n.addr[31:0] = mrg(s.addr[31:0], s.wD, s.wS);
        cmbp_pkg::OFS_ADDR_HI: n.addr[39:32] = s.wS[0] ? s.wD[7:0] : s.addr[39:32];
        cmbp_pkg::OFS_WDATA: n.wdata = mrg(s.wdata, s.wD, s.wS);
        cmbp_pkg::OFS_RDATA, cmbp_pkg::OFS_STATUS: n.sbR = cmbp_pkg::RESP_OKAY;
        default: n.sbR = cmbp_pkg::RESP_SLVERR;
      endcase
    end
    if (clrErr) n.err = 1'b0;
    if (s.srV && s_axi_rready) n.srV = 1'b0;
    if (s_axi_arvalid && s.arRdy)
    begin
      n.srV = 1'b1;
      n.srR = cmbp_pkg::RESP_OKAY;
      case (s_axi_araddr)
        cmbp_pkg::OFS_CTRL: n.srD = {17'h00000, s.prot, s.cache, 1'b0, s.bar, s.cls, 4'h0};
        cmbp_pkg::OFS_ADDR_LO: n.srD = s.addr[31:0];
        cmbp_pkg::OFS_ADDR_HI: n.srD = {24'h000000, s.addr[39:32]};
        cmbp_pkg::OFS_WDATA: n.srD = s.wdata;
        cmbp_pkg::OFS_RDATA: n.srD = s.rdata;
        cmbp_pkg::OFS_STATUS: n.srD = {22'h000000, s.lastResp, s.cfgValid, s.cfg, s.lastLocal, s.err, busy};
        default:
        begin
          n.srD = 32'h00000000;
          n.srR = cmbp_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.awRdy = !n.awHeld && !n.sbV;
    n.wRdy = !n.wHeld && !n.sbV;
    n.arRdy = !n.srV;
    // Straps are caught at the first edge after release, then never again.
    if (!s.cfgValid)
    begin
      n.cfg = {barrierSuppress, maintenanceBroadcastEn, outerShareBroadcastEn, innerShareBroadcastEn};
      n.cfgValid = 1'b1;
    end
    if (dirtyClr) n.lineDirty = 1'b0;
    if (masterBusClockEnable)
    begin
      case (s.st)
        cmbp_pkg::ST_IDLE:
        begin
          n.dom = clsDomain(s.cls);
          n.barOut = s.bar ? cmbp_pkg::BAR_MEM : cmbp_pkg::BAR_NONE;
          n.arSn = s.cls == cmbp_pkg::CLS_MAINT ? cmbp_pkg::AR_SNOOP_MAINT : cmbp_pkg::AR_SNOOP_PLAIN;
          n.busAddr = s.addr;
          n.busW = s.wdata;
          n.busCache = s.cache;
          n.busProt = s.prot;
          n.lastLocal = staysLocal(s.cls, s.bar, s.cfg);
          if (s.cfgValid && s.pendWr)
          begin
            n.pendWr = 1'b0;
            if (staysLocal(s.cls, s.bar, s.cfg))
            begin
              n.lineAddr = s.addr;
              n.lineData = {4{s.wdata}};
              n.lineDirty = 1'b1;
            end
            else
            begin
              n.awV = 1'b1;
              n.wV = 1'b1;
              n.st = cmbp_pkg::ST_WADDR;
            end
          end
          else if (s.cfgValid && s.pendRd)
          begin
            n.pendRd = 1'b0;
            if (staysLocal(s.cls, s.bar, s.cfg))
              n.rdata = s.lineData[31:0];
            else
            begin
              n.arV = 1'b1;
              n.st = cmbp_pkg::ST_RADDR;
            end
          end
        end
        cmbp_pkg::ST_WADDR:
        begin
          if (awReady) n.awV = 1'b0;
          if (wReady) n.wV = 1'b0;
          if (!n.awV && !n.wV)
          begin
            n.bRdy = 1'b1;
            n.st = cmbp_pkg::ST_WRESP;
          end
        end
        cmbp_pkg::ST_WRESP:
        begin
          if (bValid)
          begin
            n.bRdy = 1'b0;
            n.wack = 1'b1;
            n.lastResp = bResp;
            if (bResp[1]) n.err = 1'b1;
            n.st = cmbp_pkg::ST_IDLE;
          end
        end
        cmbp_pkg::ST_RADDR:
        begin
          if (arReady)
          begin
            n.arV = 1'b0;
            n.rRdy = 1'b1;
            n.st = cmbp_pkg::ST_RDATA;
          end
        end
        cmbp_pkg::ST_RDATA:
        begin
          if (rValid)
          begin
            n.rdata = rData[31:0];
            n.lastResp = rResp[1:0];
            if (rResp[1]) n.err = 1'b1;
            if (rLast)
            begin
              n.rRdy = 1'b0;
              n.rack = 1'b1;
              n.st = cmbp_pkg::ST_IDLE;
            end
          end
        end
        default: n.st = cmbp_pkg::ST_IDLE;
      endcase
    end
    else
    begin
      n.rack = s.rack;
      n.wack = s.wack;
    end
    n.irqN = !n.err;
    n.idleStby = &cpuWfiStandby && snoopSideInactive && !busy && snoopIdle;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.irqN <= 1'b1;
    end
    else s <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  cmbp_snoop u_snoop (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(masterBusClockEnable),
    .snoopSideInactive(snoopSideInactive),
    .acValid(acValid),
    .acAddr(acAddr),
    .acProt(acProt),
    .acSnoop(acSnoop),
    .acReady(acReady),
    .crValid(crValid),
    .crResp(crResp),
    .crReady(crReady),
    .cdValid(cdValid),
    .cdData(cdData),
    .cdLast(cdLast),
    .cdReady(cdReady),
    .lineAddr(s.lineAddr),
    .lineData(s.lineData),
    .lineDirty(s.lineDirty),
    .dirtyClr(dirtyClr),
    .snoopIdle(snoopIdle)
  );

  assign s_axi_awready = s.awRdy;
  assign s_axi_wready = s.wRdy;
  assign s_axi_bvalid = s.sbV;
  assign s_axi_bresp = s.sbR;
  assign s_axi_arready = s.arRdy;
  assign s_axi_rvalid = s.srV;
  assign s_axi_rdata = s.srD;
  assign s_axi_rresp = s.srR;
  assign busErrorIrqN = s.irqN;
  assign sharedCacheIdleStandby = s.idleStby;
  assign awValid = s.awV;
  assign awAddr = s.busAddr;
  assign awId = cmbp_pkg::WR_ID;
  assign awLen = cmbp_pkg::BURST_LEN;
  assign awSize = cmbp_pkg::BURST_SIZE;
  assign awBurst = cmbp_pkg::BURST_INCR;
  assign awCache = s.busCache;
  assign awProt = s.busProt;
  assign awDomain = s.dom;
  assign awBar = s.barOut;
  assign awSnoop = cmbp_pkg::AW_SNOOP_PLAIN;
  assign awLock = 1'b0;
  assign wValid = s.wV;
  assign wData = {4{s.busW}};
  assign wStrb = 16'hFFFF;
  assign wId = cmbp_pkg::WR_ID;
  assign wLast = 1'b1;
  assign bReady = s.bRdy;
  assign arValid = s.arV;
  assign arAddr = s.busAddr;
  assign arId = cmbp_pkg::RD_ID;
  assign arLen = cmbp_pkg::BURST_LEN;
  assign arSize = cmbp_pkg::BURST_SIZE;
  assign arBurst = cmbp_pkg::BURST_INCR;
  assign arCache = s.busCache;
  assign arProt = s.busProt;
  assign arDomain = s.dom;
  assign arBar = s.barOut;
  assign arSnoop = s.arSn;
  assign arLock = 1'b0;
  assign rReady = s.rRdy;
  assign readAck = s.rack;
  assign writeAck = s.wack;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_cfg_frozen: assert property (s.cfgValid |=> $stable(s.cfg)) else $error("strap changed");
  a_inner_out: assert property (awValid && awDomain == cmbp_pkg::DOM_INNER |-> s.cfg[0] || s.cfg[2])
    else $error("inner shareable issued while disabled");
  a_outer_out: assert property ((awValid || arValid) && arDomain == cmbp_pkg::DOM_OUTER |-> s.cfg[1])
    else $error("outer shareable issued while disabled");
  a_maint_out: assert property (arValid && arSnoop == cmbp_pkg::AR_SNOOP_MAINT |-> s.cfg[2])
    else $error("maintenance forwarded while disabled");
  a_bar_supp: assert property ((awValid || arValid) && awBar != cmbp_pkg::BAR_NONE |-> !s.cfg[3])
    else $error("barrier issued while suppressed");
  a_bus_gated: assert property (!masterBusClockEnable |=> $stable({awValid, wValid, bReady, arValid, rReady}))
    else $error("bus moved without enable");
  a_irq_hold: assert property (!busErrorIrqN && !clrErr |=> !busErrorIrqN) else $error("irq released");
  a_irq_err: assert property (masterBusClockEnable && bValid && bReady && bResp[1] |=> !busErrorIrqN)
    else $error("bus error not flagged");
  a_aw_hold: assert property (awValid && !(masterBusClockEnable && awReady) |=> awValid && $stable(awAddr))
    else $error("write address dropped");
  a_wack_cause: assert property (masterBusClockEnable && bValid && bReady |=> writeAck)
    else $error("write acknowledge missing");
  a_standby: assert property (sharedCacheIdleStandby |-> $past(snoopSideInactive) && $past(&cpuWfiStandby))
    else $error("standby without idle conditions");
endmodule
`default_nettype wire

// >>> cmbp_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cmbp_port_tb;
  logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, awLock, arLock, wLast, rLast, cdLast;
  logic masterBusClockEnable, snoopSideInactive, innerShareBroadcastEn, outerShareBroadcastEn, icErr;
  logic maintenanceBroadcastEn, barrierSuppress, busErrorIrqN, sharedCacheIdleStandby, readAck, writeAck;
  logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady, rdChk;
  logic acValid, acReady, crValid, crReady, cdValid, cdReady;
  logic [7:0] s_axi_awaddr, s_axi_araddr, awLen, arLen;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv, d, a;
  logic [3:0] s_axi_wstrb, cpuWfiStandby, awCache, arCache, arSnoop, rResp, acSnoop;
  logic [1:0] s_axi_bresp, s_axi_rresp, awBurst, awDomain, awBar, arBurst, arDomain, arBar, bResp;
  logic [39:0] awAddr, arAddr, acAddr;
  logic [4:0] awId, wId, bId, crResp;
  logic [2:0] awSize, awProt, awSnoop, arSize, arProt, acProt;
  logic [5:0] arId, rId;
  logic [127:0] wData, rData, cdData;
  logic [15:0] wStrb;
  logic [127:0] expQ[$], mskQ[$];
  int failures = 0, checked = 0, ackCnt = 0, seed;
  logic [3:0] straps[3] = '{4'h0, 4'h7, 4'h8};
  logic loc, wrOp;

  cmbp_port dut (.*);
  cmbp_ic_model icm (.*);
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Enable is never low two cycles running.
  always @(posedge core_clk)
    masterBusClockEnable <= !masterBusClockEnable || $urandom % 2;
  always @(posedge core_clk)
  begin
    if (masterBusClockEnable && (readAck || writeAck)) ackCnt++;
    if (s_axi_rvalid && s_axi_rready && rdChk) cmp({96'h0, s_axi_rdata});
    if (masterBusClockEnable && wValid && wReady) cmp(wData);
    if (masterBusClockEnable && crValid && crReady) cmp({123'h0, crResp});
    if (masterBusClockEnable && cdValid && cdReady) cmp(cdData);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [127:0] g);
    logic [127:0] e = '1, m = '0;
    if (expQ.size() > 0)
    begin
      e = expQ.pop_front();
      m = mskQ.pop_front();
    end
    `CHK(g & m, e)
  endtask
  task automatic stop_test();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic to();
    failures++;
    stop_test();
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    int n = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while ((s_axi_awvalid || s_axi_wvalid || s_axi_bready) && n < 200);
    @(posedge core_clk);
    if (n >= 200) to();
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] m, e);
    int n = 0;
    rdChk = (m != 0);
    if (rdChk)
    begin
      expQ.push_back({96'h0, e});
      mskQ.push_back({96'h0, m});
    end
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    s_axi_araddr <= ad;
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
      if (s_axi_rvalid) rdv = s_axi_rdata;
    end while ((s_axi_arvalid || s_axi_rready) && n < 200);
    @(posedge core_clk);
    if (n >= 200) to();
  endtask
  task automatic boot(input logic [3:0] s);
    {barrierSuppress, maintenanceBroadcastEn, outerShareBroadcastEn, innerShareBroadcastEn} <= s;
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic op(input logic [31:0] c, input logic lc);
    int n = 0, a0;
    a0 = ackCnt;
    wr(cmbp_pkg::OFS_CTRL, c);
    repeat (3) @(posedge core_clk);
    do
    begin
      rd(cmbp_pkg::OFS_STATUS, 32'h0, 32'h0);
      n++;
    end while (rdv[0] !== 1'b0 && n < 100);
    if (n >= 100) to();
    rd(cmbp_pkg::OFS_STATUS, 32'h4, {29'h0, lc, 2'h0});
    `CHK(ackCnt - a0, int'(!lc))
  endtask
  task automatic snp(input logic [39:0] ad);
    int n = 0;
    acValid <= 1'b1;
    acAddr <= ad;
    acSnoop <= 4'($urandom);
    acProt <= 3'($urandom);
    do
    begin
      @(posedge core_clk);
      n++;
    end while (!(masterBusClockEnable && acReady) && n < 200);
    acValid <= 1'b0;
    if (n >= 200) to();
    repeat (8) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, crReady, cdReady, s_axi_wstrb} = 7'h7F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, acValid, icErr} = '0;
    {masterBusClockEnable, snoopSideInactive, cpuWfiStandby, rdChk} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, acAddr, acSnoop, acProt} = '0;
    {barrierSuppress, maintenanceBroadcastEn, outerShareBroadcastEn, innerShareBroadcastEn} = '0;
    seed = $urandom(77762);
    boot(4'h0);
    `CHK(busErrorIrqN, 1'b1)
    rd(cmbp_pkg::OFS_STATUS, 32'hF8, 32'h80);
    {outerShareBroadcastEn, innerShareBroadcastEn} <= 2'b11;
    repeat (3) @(posedge core_clk);
    rd(cmbp_pkg::OFS_STATUS, 32'hF8, 32'h80);
    foreach (straps[i])
    begin
      boot(straps[i]);
      for (int k = 0; k < 8; k++)
      begin
        loc = (k % 4 == 1 && !straps[i][0]) || (k % 4 == 2 && !straps[i][1]) || (k % 4 == 3 && !straps[i][2])
          || (k >= 4 && straps[i][3]);
        wrOp = (k % 4 != 3) && $urandom % 2;
        d = $urandom;
        wr(cmbp_pkg::OFS_WDATA, d);
        wr(cmbp_pkg::OFS_ADDR_LO, $urandom & 32'hFFFFFFF0);
        if (wrOp && !loc) expQ.push_back({4{d}});
        if (wrOp && !loc) mskQ.push_back('1);
        op($urandom & 32'h7F00 | 32'({25'(k / 4), 2'(k % 4), 2'h0, !wrOp, wrOp}), loc);
      end
    end
    icErr <= 1'b1;
    op(32'h2, 1'b0);
    `CHK(busErrorIrqN, 1'b0)
    repeat (20) @(posedge core_clk);
    `CHK(busErrorIrqN, 1'b0)
    icErr <= 1'b0;
    wr(cmbp_pkg::OFS_CTRL, 32'h4);
    repeat (3) @(posedge core_clk);
    `CHK(busErrorIrqN, 1'b1)
    a = $urandom & 32'hFFFFFFF0;
    wr(cmbp_pkg::OFS_ADDR_LO, a);
    wr(cmbp_pkg::OFS_ADDR_HI, 32'h0);
    op(32'h11, 1'b1);
    expQ = '{128'h0, 128'h5, {4{d}}, 128'h0};
    mskQ = '{128'h1F, 128'h1F, '1, 128'h1F};
    snp({8'h0, a + 32'h10});
    snp({8'h0, a});
    snp({8'h0, a});
    cpuWfiStandby <= 4'hF;
    snoopSideInactive <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(sharedCacheIdleStandby, 1'b1)
    `CHK(acReady, 1'b0)
    cpuWfiStandby <= 4'h7;
    repeat (3) @(posedge core_clk);
    `CHK(sharedCacheIdleStandby, 1'b0)
    rd(8'h3C, 32'hFFFFFFFF, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire

// >>> cmbp_snoop.sv
`timescale 1ns/1ns
`default_nettype none
module cmbp_snoop (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic snoopSideInactive,
  input wire logic acValid,
  input wire logic [39:0] acAddr,
  input wire logic [2:0] acProt,
  input wire logic [3:0] acSnoop,
  output logic acReady,
  output logic crValid,
  output logic [4:0] crResp,
  input wire logic crReady,
  output logic cdValid,
  output logic [127:0] cdData,
  output logic cdLast,
  input wire logic cdReady,
  input wire logic [39:0] lineAddr,
  input wire logic [127:0] lineData,
  input wire logic lineDirty,
  output logic dirtyClr,
  output logic snoopIdle
);
  typedef struct packed {
    cmbp_pkg::cmbp_snoop_state_t st;
    logic acRdy;
    logic crV;
    logic [4:0] crR;
    logic cdV;
    logic [127:0] cdD;
    logic clr;
  } cmbp_snoop_t;
  cmbp_snoop_t s;
  cmbp_snoop_t n;
  logic hit;

  ////////////////////////////////////////////////////////////////////////////
  // A snoop hits only the single dirty line; the rest of the cluster is clean.
  assign hit = lineDirty && acAddr[39:cmbp_pkg::LINE_LSB] == lineAddr[39:cmbp_pkg::LINE_LSB];

  always_comb
  begin
    n = s;
    n.clr = 1'b0;
    if (clkEn)
    begin
      case (s.st)
        cmbp_pkg::SN_IDLE:
        begin
          n.acRdy = !snoopSideInactive;
          if (acValid && s.acRdy)
          begin
            n.acRdy = 1'b0;
            n.crV = 1'b1;
            n.crR = hit ? cmbp_pkg::CR_HIT_DIRTY : cmbp_pkg::CR_MISS;
            n.cdV = hit;
            n.cdD = lineData;
            n.clr = hit;
            n.st = cmbp_pkg::SN_BUSY;
          end
        end
        cmbp_pkg::SN_BUSY:
        begin
          if (s.crV && crReady) n.crV = 1'b0;
          if (s.cdV && cdReady) n.cdV = 1'b0;
          if (!n.crV && !n.cdV) n.st = cmbp_pkg::SN_IDLE;
        end
        default: n.st = cmbp_pkg::SN_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) s <= '0;
    else s <= n;
  end

  assign acReady = s.acRdy;
  assign crValid = s.crV;
  assign crResp = s.crR;
  assign cdValid = s.cdV;
  assign cdData = s.cdD;
  assign cdLast = s.cdV;
  assign dirtyClr = s.clr;
  assign snoopIdle = s.st == cmbp_pkg::SN_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence acTaken;
    clkEn && acValid && acReady;
  endsequence
  a_snoop_answer: assert property (acTaken |=> crValid && !acReady) else $error("no snoop response");
  a_snoop_data: assert property (acTaken ##1 cdValid |-> crResp == cmbp_pkg::CR_HIT_DIRTY && cdLast)
    else $error("snoop data without dirty response");
  a_cr_hold: assert property (crValid && !(clkEn && crReady) |=> crValid && $stable(crResp))
    else $error("snoop response dropped");
endmodule
`default_nettype wire
